// File: hw/sfd_pkg.sv
// Purpose: constants for the shared-address register decode block
// Assumes: 12-bit register address, 8-bit data, 12-bit data memory address
// Notes: offsets are the printed special-function addresses
package sfd_pkg;
    localparam logic [11:0] ADDR_SLAVE_ADDR = 12'hfc8;
    localparam logic [11:0] ADDR_CTRL_SECOND = 12'hfc5;
    localparam logic [11:0] ADDR_PTR1_HIGH = 12'hfe2;
    localparam logic [11:0] ADDR_PTR1_LOW = 12'hfe1;
    localparam logic [11:0] ADDR_INDIRECT1 = 12'hfe7;
    localparam logic [11:0] ADDR_PAR_PAIR_H = 12'hf6f;
    localparam logic [11:0] ADDR_PAR_PAIR_L = 12'hf6e;
    localparam logic [11:0] ADDR_PAR_OUT2_H = 12'hf5b;
    localparam logic [11:0] ADDR_PAR_OUT2_L = 12'hf5a;
    localparam logic [11:0] ADDR_PORTA_DIR = 12'hf92;
    localparam logic [11:0] ADDR_OSC_CTRL = 12'hfd3;
    localparam logic [7:0] RST_SLAVE_ADDR = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] RST_CTRL_SECOND = 8'h00;
    localparam logic [7:0] RST_PTR1_HIGH = 8'h00;
    localparam logic [7:0] RST_PTR1_LOW = 8'h00;
    localparam logic [7:0] RST_PAR = 8'h00;
    localparam logic [7:0] RST_PORTA_DIR = 8'hef;
    localparam logic [7:0] RST_OSC_CTRL = 8'h60;
    localparam logic [3:0] MASK_MODE = 4'h9;
    localparam logic [7:0] PORTA_IMPL = 8'hef;
    localparam logic [7:0] PORTA_OSC_BITS = 8'hc0;
    localparam logic [7:0] PTR_HIGH_IMPL = 8'h0f;
    localparam logic [7:0] OSC_CTRL_IMPL = 8'hf3;
    localparam int OSC_STATUS_BIT = 3;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    typedef enum logic [1:0] {
        SFD_IDLE = 2'b00,
        SFD_HOLD = 2'b01
    } sfd_state_type;
endpackage

// File: hw/sfd_sfr_decode.sv
// Purpose: special-function register decode with shared addresses
// Assumes: one access per cycle; reads answered from flip-flops next cycle, indirect reads one cycle after that
// Notes: indirect access is forwarded on the data memory port
// Summary of operation
// [R1] slave address and address mask are two registers at one address
// [R2] serial mode picks which of the two a shared access reaches
// [R3] mask reachable only when second control low nibble is 1001
// [R4] parallel address pair and data-out pair are the same flip-flops
// [R5] pair means address in master modes, output data in slave modes
// [R6] bits for the larger package exist only there, else read zero
// [R7] port A direction bits 6 and 7 exist only without oscillator pins
// [R8] oscillator start-up status resets to 0 with two-speed, else 1
// [R9] indirect register uses pointer one as the memory address
// [R10] in slave mode control bits serve as address mask enables
// [R11] unimplemented addresses read as zero
// [R12] shared-address write touches only the selected register
module sfd_sfr_decode (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // configuration straps
    input wire logic LARGE_PKG,
    input wire logic OSC_PINS_PRIMARY,
    input wire logic TWO_SPEED_EN,
    input wire logic PAR_MASTER_MODE,
    input wire logic SER_SLAVE_MODE,
    // register bus from the core
    input wire logic [11:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // data memory port for indirect access
    output logic [11:0] MEM_ADDR,
    output logic MEM_WR,
    output logic MEM_RD,
    output logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    // block outputs
    output logic [15:0] PAR_ADDR,
    output logic [15:0] PAR_DOUT,
    output logic [7:0] MATCH_MASK,
    output logic [4:0] MASK_ENABLES
);
    logic rst_s1_r, rst_s2_r;
    logic [7:0] slave_addr_r, mask_r, ctrl2_r, ptr_h_r, ptr_l_r;
    logic [7:0] par_h_r, par_l_r, porta_r, osc_r;
    logic [7:0] rdata_r;
    logic [11:0] mem_addr_r;
    logic mem_wr_r, mem_rd_r;
    logic [7:0] mem_wdata_r;
    logic [15:0] par_addr_r, par_dout_r;
    logic [7:0] match_mask_r;
    logic [4:0] mask_en_r;
    logic osc_init_r;
    sfd_pkg::sfd_state_type state_r, state_nxt;

    // release of reset through two flops
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire rst_n = rst_s2_r;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        hit = (a == b);
    endfunction

    wire mask_sel = (ctrl2_r[3:0] == sfd_pkg::MASK_MODE); // [R2] [R3]
    wire hit_ssp = hit(SFR_ADDR, sfd_pkg::ADDR_SLAVE_ADDR);
    // both names decode to one pair, 44-pin only
    wire hit_par_h = LARGE_PKG && (hit(SFR_ADDR, sfd_pkg::ADDR_PAR_PAIR_H)
        || hit(SFR_ADDR, sfd_pkg::ADDR_PAR_OUT2_H)); // [R4] [R6]
    wire hit_par_l = LARGE_PKG && (hit(SFR_ADDR, sfd_pkg::ADDR_PAR_PAIR_L)
        || hit(SFR_ADDR, sfd_pkg::ADDR_PAR_OUT2_L)); // [R4] [R6]
    wire hit_ind = hit(SFR_ADDR, sfd_pkg::ADDR_INDIRECT1);
    wire [7:0] porta_impl = OSC_PINS_PRIMARY ?
        (sfd_pkg::PORTA_IMPL & ~sfd_pkg::PORTA_OSC_BITS)
        : sfd_pkg::PORTA_IMPL; // [R7]
    wire wr_slave = SFR_WR && hit_ssp && !mask_sel; // [R12]
    wire wr_mask = SFR_WR && hit_ssp && mask_sel; // [R12]
    wire [7:0] ssp_view = mask_sel ? mask_r : slave_addr_r; // [R1]
    wire [11:0] ptr_addr = {ptr_h_r[3:0], ptr_l_r}; // [R9]

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = sfd_pkg::ZERO_BYTE; // [R11]
        case (SFR_ADDR)
            sfd_pkg::ADDR_SLAVE_ADDR: rd_mux = ssp_view;
            sfd_pkg::ADDR_CTRL_SECOND: rd_mux = ctrl2_r;
            sfd_pkg::ADDR_PTR1_HIGH: rd_mux = ptr_h_r;
            sfd_pkg::ADDR_PTR1_LOW: rd_mux = ptr_l_r;
            sfd_pkg::ADDR_PORTA_DIR: rd_mux = porta_r & porta_impl; // [R7]
            sfd_pkg::ADDR_OSC_CTRL: rd_mux = osc_r;
            default: begin
                if (hit_par_h)
                    rd_mux = par_h_r;
                else if (hit_par_l)
                    rd_mux = par_l_r;
                else
                    rd_mux = sfd_pkg::ZERO_BYTE; // [R6] [R11]
            end
        endcase
    end

    // indirect read data returns one cycle after the memory strobe
    always_comb begin
        case (state_r)
            sfd_pkg::SFD_IDLE:
                state_nxt = (SFR_RD && hit_ind) ? sfd_pkg::SFD_HOLD
                    : sfd_pkg::SFD_IDLE;
            sfd_pkg::SFD_HOLD: state_nxt = sfd_pkg::SFD_IDLE;
            default: state_nxt = sfd_pkg::SFD_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            slave_addr_r <= sfd_pkg::RST_SLAVE_ADDR;
            mask_r <= sfd_pkg::RST_MASK;
            ctrl2_r <= sfd_pkg::RST_CTRL_SECOND;
            ptr_h_r <= sfd_pkg::RST_PTR1_HIGH;
            ptr_l_r <= sfd_pkg::RST_PTR1_LOW;
            par_h_r <= sfd_pkg::RST_PAR;
            par_l_r <= sfd_pkg::RST_PAR;
            porta_r <= sfd_pkg::RST_PORTA_DIR;
            osc_r <= sfd_pkg::RST_OSC_CTRL;
            osc_init_r <= 1'b1;
        end else begin
            osc_init_r <= 1'b0;
            if (wr_slave)
                slave_addr_r <= SFR_WDATA; // [R1] [R12]
            if (wr_mask)
                mask_r <= SFR_WDATA; // [R1] [R12]
            if (SFR_WR && hit(SFR_ADDR, sfd_pkg::ADDR_CTRL_SECOND))
                ctrl2_r <= SFR_WDATA;
            if (SFR_WR && hit(SFR_ADDR, sfd_pkg::ADDR_PTR1_HIGH))
                ptr_h_r <= SFR_WDATA & sfd_pkg::PTR_HIGH_IMPL;
            if (SFR_WR && hit(SFR_ADDR, sfd_pkg::ADDR_PTR1_LOW))
                ptr_l_r <= SFR_WDATA;
            if (SFR_WR && hit_par_h)
                par_h_r <= SFR_WDATA; // [R4]
            if (SFR_WR && hit_par_l)
                par_l_r <= SFR_WDATA; // [R4]
            if (SFR_WR && hit(SFR_ADDR, sfd_pkg::ADDR_PORTA_DIR))
                porta_r <= SFR_WDATA & porta_impl; // [R7]
            // strap sampled after reset release, not under reset
            if (osc_init_r)
                osc_r[sfd_pkg::OSC_STATUS_BIT] <= !TWO_SPEED_EN; // [R8]
            else if (SFR_WR && hit(SFR_ADDR, sfd_pkg::ADDR_OSC_CTRL))
                osc_r <= (SFR_WDATA & sfd_pkg::OSC_CTRL_IMPL
                    & ~(8'h01 << sfd_pkg::OSC_STATUS_BIT))
                    | (osc_r & (8'h01 << sfd_pkg::OSC_STATUS_BIT));
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= sfd_pkg::SFD_IDLE;
            rdata_r <= sfd_pkg::ZERO_BYTE;
            mem_addr_r <= 12'h000;
            mem_wr_r <= 1'b0;
            mem_rd_r <= 1'b0;
            mem_wdata_r <= sfd_pkg::ZERO_BYTE;
        end else begin
            state_r <= state_nxt;
            mem_addr_r <= ptr_addr; // [R9]
            mem_wr_r <= SFR_WR && hit_ind; // [R9]
            mem_rd_r <= SFR_RD && hit_ind; // [R9]
            mem_wdata_r <= SFR_WDATA;
            if (state_r == sfd_pkg::SFD_HOLD)
                rdata_r <= MEM_RDATA; // [R9]
            else if (SFR_RD && !hit_ind)
                rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            par_addr_r <= 16'h0000;
            par_dout_r <= 16'h0000;
            match_mask_r <= sfd_pkg::RST_MASK;
            mask_en_r <= 5'h00;
        end else begin
            // one pair, meaning taken from the port mode
            par_addr_r <= PAR_MASTER_MODE ? {par_h_r, par_l_r}
                : par_addr_r; // [R5]
            par_dout_r <= PAR_MASTER_MODE ? par_dout_r
                : {par_h_r, par_l_r}; // [R5]
            match_mask_r <= mask_r;
            mask_en_r <= SER_SLAVE_MODE ? ctrl2_r[5:1] : 5'h00; // [R10]
        end
    end

    assign SFR_RDATA = rdata_r;
    assign MEM_ADDR = mem_addr_r;
    assign MEM_WR = mem_wr_r;
    assign MEM_RD = mem_rd_r;
    assign MEM_WDATA = mem_wdata_r;
    assign PAR_ADDR = par_addr_r;
    assign PAR_DOUT = par_dout_r;
    assign MATCH_MASK = match_mask_r;
    assign MASK_ENABLES = mask_en_r;

    AST_MASK_WRITE: assert property ( // [R3]
        @(posedge CORE_CLK) disable iff (!rst_n)
        wr_mask |=> mask_r == $past(SFR_WDATA))
        else $error("mask write lost");
    AST_SLAVE_HELD: assert property ( // [R12]
        @(posedge CORE_CLK) disable iff (!rst_n)
        wr_mask |=> $stable(slave_addr_r))
        else $error("slave address changed on mask write");
    AST_MASK_HELD: assert property ( // [R12]
        @(posedge CORE_CLK) disable iff (!rst_n)
        wr_slave |=> $stable(mask_r))
        else $error("mask changed on address write");
    AST_SHARED_READ: assert property ( // [R2]
        @(posedge CORE_CLK) disable iff (!rst_n)
        SFR_RD && hit_ssp && !mask_sel && !wr_slave
        |=> SFR_RDATA == slave_addr_r)
        else $error("shared read wrong register");
    AST_PAR_ALIAS: assert property ( // [R4]
        @(posedge CORE_CLK) disable iff (!rst_n)
        SFR_WR && LARGE_PKG && hit(SFR_ADDR, sfd_pkg::ADDR_PAR_OUT2_L)
        |=> par_l_r == $past(SFR_WDATA))
        else $error("parallel alias write lost");
    AST_SMALL_PKG: assert property ( // [R6]
        @(posedge CORE_CLK) disable iff (!rst_n)
        SFR_RD && !LARGE_PKG && hit(SFR_ADDR, sfd_pkg::ADDR_PAR_PAIR_H)
        |=> SFR_RDATA == 8'h00)
        else $error("absent register read nonzero");
    AST_OSC_STRAP: assert property ( // [R8]
        @(posedge CORE_CLK) disable iff (!rst_n)
        osc_init_r |=> osc_r[sfd_pkg::OSC_STATUS_BIT] == !$past(TWO_SPEED_EN))
        else $error("start-up status reset value wrong");
    AST_IND_ADDR: assert property ( // [R9]
        @(posedge CORE_CLK) disable iff (!rst_n)
        SFR_RD && hit_ind |=> MEM_RD && MEM_ADDR == $past(ptr_addr)
        ##1 SFR_RDATA == $past(MEM_RDATA))
        else $error("indirect access wrong");
    AST_PORTA_OSC: assert property ( // [R7]
        @(posedge CORE_CLK) disable iff (!rst_n)
        SFR_RD && OSC_PINS_PRIMARY && hit(SFR_ADDR, sfd_pkg::ADDR_PORTA_DIR)
        |=> SFR_RDATA[7:6] == 2'b00)
        else $error("oscillator direction bits visible");
    AST_MASK_EN: assert property ( // [R10]
        @(posedge CORE_CLK) disable iff (!rst_n)
        !SER_SLAVE_MODE |=> MASK_ENABLES == 5'h00)
        else $error("mask enables outside slave mode");
    AST_UNMAPPED: assert property ( // [R11]
        @(posedge CORE_CLK) disable iff (!rst_n)
        SFR_RD && SFR_ADDR == 12'h000 |=> SFR_RDATA == 8'h00)
        else $error("unmapped read nonzero");

    COV_MASK_ACCESS: cover property (@(posedge CORE_CLK) wr_mask);
    COV_SLAVE_ACCESS: cover property (@(posedge CORE_CLK) wr_slave);
    COV_INDIRECT: cover property (@(posedge CORE_CLK) SFR_RD && hit_ind);
    COV_PAR_ALIAS: cover property (@(posedge CORE_CLK) SFR_WR && hit_par_l);
endmodule // sfd_sfr_decode

// File: testbench/sfd_sfr_decode_test.sv
// Purpose: self-checking bench for the shared-address register decode
// Assumes: read data sampled two edges after the taking edge
// Notes: straps change only between accesses, never mid-access
module shared_address_sfr_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic large_pkg = 1'b1;
    logic osc_pri = 1'b0;
    logic two_speed = 1'b0;
    logic par_master = 1'b1;
    logic ser_slave = 1'b0;
    logic [11:0] addr = 12'h000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] rdata, mem_wdata, match_mask, seen_wdata;
    logic [11:0] mem_addr, seen_raddr, seen_waddr;
    logic mem_wr, mem_rd;
    logic [15:0] par_addr, par_dout;
    logic [4:0] mask_en;
    int bad_count = 0;
    int num_checks = 0;
    int mem_rd_n = 0;
    int mem_wr_n = 0;
    int cycles = 0;

    sfd_sfr_decode sfd_sfr_decode_i (.CORE_CLK(clk), .RST_N(rst_n),
        .LARGE_PKG(large_pkg), .OSC_PINS_PRIMARY(osc_pri),
        .TWO_SPEED_EN(two_speed), .PAR_MASTER_MODE(par_master),
        .SER_SLAVE_MODE(ser_slave), .SFR_ADDR(addr), .SFR_WR(wr),
        .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .MEM_ADDR(mem_addr), .MEM_WR(mem_wr), .MEM_RD(mem_rd),
        .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
        .PAR_ADDR(par_addr), .PAR_DOUT(par_dout),
        .MATCH_MASK(match_mask), .MASK_ENABLES(mask_en));

    always #5 clk = ~clk;

    // memory strobes are one-cycle pulses, so count them at every edge
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (mem_rd === 1'b1) begin
            mem_rd_n <= mem_rd_n + 1;
            seen_raddr <= mem_addr;
        end
        if (mem_wr === 1'b1) begin
            mem_wr_n <= mem_wr_n + 1;
            seen_waddr <= mem_addr;
            seen_wdata <= mem_wdata;
        end
        if (cycles == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // two edges after taking covers the indirect path as well
    task automatic expect_rd(input string what, input logic [11:0] a,
            input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(what, {8'h00, rdata}, {8'h00, e});
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask

    task automatic t_reset();
        expect_rd("slave addr", 12'hfc8, 8'h00);
        expect_rd("ctrl2", 12'hfc5, 8'h00);
        expect_rd("ptr high", 12'hfe2, 8'h00);
        expect_rd("port a dir", 12'hf92, 8'hef);
        expect_rd("osc ctrl", 12'hfd3, 8'h68);
        expect_rd("unmapped", 12'h123, 8'h00);
        expect_rd("unmapped zero", 12'h000, 8'h00);
        check("match mask", {8'h00, match_mask}, 16'h00ff);
    endtask

    task automatic t_shared();
        bus_wr(12'hfc8, 8'h5a);
        bus_wr(12'hfc5, 8'h09);
        bus_wr(12'hfc8, 8'h3c);
        settle();
        check("mask out", {8'h00, match_mask}, 16'h003c);
        expect_rd("mask view", 12'hfc8, 8'h3c);
        bus_wr(12'hfc5, 8'h08);
        expect_rd("addr view", 12'hfc8, 8'h5a);
        check("mask kept", {8'h00, match_mask}, 16'h003c);
    endtask

    task automatic t_mask_en();
        bus_wr(12'hfc5, 8'h2a);
        ser_slave <= 1'b1;
        settle();
        check("mask enables", {11'h000, mask_en}, 16'h0015);
        @(posedge clk);
        ser_slave <= 1'b0;
        settle();
        check("enables off", {11'h000, mask_en}, 16'h0000);
    endtask

    task automatic t_par();
        bus_wr(12'hf6f, 8'h12);
        bus_wr(12'hf6e, 8'h34);
        expect_rd("out2 high", 12'hf5b, 8'h12);
        expect_rd("out2 low", 12'hf5a, 8'h34);
        check("par addr", par_addr, 16'h1234);
        check("par dout", par_dout, 16'h0000);
        @(posedge clk);
        par_master <= 1'b0;
        bus_wr(12'hf5a, 8'h56);
        settle();
        check("dout slave", par_dout, 16'h1256);
        check("addr held", par_addr, 16'h1234);
        expect_rd("pair low", 12'hf6e, 8'h56);
        @(posedge clk);
        large_pkg <= 1'b0;
        expect_rd("small pkg", 12'hf6f, 8'h00);
        @(posedge clk);
        large_pkg <= 1'b1;
    endtask

    task automatic t_porta();
        bus_wr(12'hf92, 8'hff);
        expect_rd("dir all", 12'hf92, 8'hef);
        @(posedge clk);
        osc_pri <= 1'b1;
        expect_rd("dir osc", 12'hf92, 8'h2f);
        @(posedge clk);
        osc_pri <= 1'b0;
    endtask

    task automatic t_indirect();
        bus_wr(12'hfe2, 8'hf3);
        expect_rd("ptr high", 12'hfe2, 8'h03);
        bus_wr(12'hfe1, 8'h45);
        expect_rd("ptr low", 12'hfe1, 8'h45);
        @(posedge clk);
        mem_rdata <= 8'ha7;
        expect_rd("indirect rd", 12'hfe7, 8'ha7);
        @(posedge clk);
        mem_rdata <= 8'h58;
        check("rd addr", {4'h0, seen_raddr}, 16'h0345);
        check("rd pulses", mem_rd_n[15:0], 16'h0001);
        bus_wr(12'hfe7, 8'h99);
        repeat (3) @(posedge clk);
        #1;
        check("wr addr", {4'h0, seen_waddr}, 16'h0345);
        check("wr data", {8'h00, seen_wdata}, 16'h0099);
        check("wr pulses", mem_wr_n[15:0], 16'h0001);
    endtask

    // status bit is read-only, so a write of zero leaves it standing
    task automatic t_osc();
        bus_wr(12'hfd3, 8'h00);
        expect_rd("osc written", 12'hfd3, 8'h08);
        @(posedge clk);
        two_speed <= 1'b1;
        do_reset();
        expect_rd("osc two speed", 12'hfd3, 8'h60);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        t_reset();
        t_shared();
        t_mask_en();
        t_par();
        t_porta();
        t_indirect();
        t_osc();
        tally_and_finish();
    end
endmodule // shared_address_sfr_decode_test
